// File: logic/ltg_pkg.sv
package ltg_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  // wake dominant time window, in microseconds
  localparam int unsigned WAKE_DOMINANT_TIME_MIN_US = 30;
  localparam int unsigned WAKE_DOMINANT_TIME_MAX_US = 150;
  // qualify at the midpoint of the window for margin both ways
  localparam int unsigned WAKE_DOMINANT_TIME_US = 90;
  localparam int unsigned WAKE_CYCLES = WAKE_DOMINANT_TIME_US * CLK_MHZ;
  // receive output recessive while bus is busy, in microseconds
  localparam int unsigned RX_STUCK_TIME_US = 50;
  localparam int unsigned RX_STUCK_CYCLES = RX_STUCK_TIME_US * CLK_MHZ;
  // transmit-to-receive short: txd dominant while rxd stays recessive
  localparam int unsigned SHORT_TIME_US = 10;
  localparam int unsigned SHORT_CYCLES = SHORT_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;

  // -----------------------------------------------------------------
  // fault fifo
  // -----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned EVT_W = 3;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    LTG_NORMAL = 4'h1,
    LTG_RX_ONLY = 4'h2,
    LTG_OVERTEMP = 4'h4,
    LTG_OT_WAIT = 4'h8
  } ltg_tx_state_e;

  // diagnostic event word handed to the spi encoder
  typedef struct packed {
    logic tx_rx_short;
    logic rx_stuck;
    logic wake;
  } ltg_evt_s;

  // line-side pin levels, 1 = recessive
  typedef struct packed {
    logic txd;
    logic bus;
  } ltg_pins_s;

endpackage

// File: logic/ltg_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ltg_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic [WIDTH-1:0] next_out_data;
  logic push, pop;

  // -------------------------------------------------------------
  // pointers and read register
  // -------------------------------------------------------------
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // read data always shows the head word, registered
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    next_out_data = mem[next_rd_ptr];
    if (push && (next_count == {{AW{1'b0}}, 1'b1})) begin
      next_out_data = in_data_i; // write into an empty fifo bypasses memory
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_data_o <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      out_data_o <= next_out_data;
    end
  end

  // storage has no reset; only valid words are ever read
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// File: logic/ltg_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ltg_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // -------------------------------------------------------------
  // two-flop synchroniser, resets to recessive
  // -------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      stage1 <= '1;
      sync_o <= '1;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: logic/ltg_guard.sv
// Functional notes
// - detect txd-rxd short, report in diagnostics
// - short inhibits transmitter until spi re-enable
// - overtemperature disables driver, reception continues
// - after overtemperature, resume on txd rising edge
// - overtemperature never reported nor interrupts
// - rxd stuck recessive with traffic disables transmitter
// - stuck-rxd fault needs spi re-enable command
// - any fault forces receive-only mode
`timescale 1ns/10ps
`default_nettype none
module ltg_guard
  import ltg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic txd_pin_i,
  input wire logic bus_pin_i,
  input wire logic rxd_fb_i,
  input wire logic overtemp_i,
  input wire logic wake_capable_i,
  input wire logic normal_cmd_i,
  output logic rxd_o,
  output logic drv_en_o,
  output logic drv_dominant_o,
  output logic rx_only_o,
  output logic wake_o,
  output logic diag_valid_o,
  input wire logic diag_ready_i,
  output ltg_evt_s diag_evt_o,
  output logic evt_drop_o
);

  // -----------------------------------------------------------------
  // pin synchronisation
  // -----------------------------------------------------------------
  ltg_pins_s pins_raw, pins;
  logic [0:0] rxfb_sync;

  assign pins_raw = '{txd: txd_pin_i, bus: bus_pin_i};

  ltg_sync #(.WIDTH(2)) u_sync_pins (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // the receive pin is read back to catch a short or a stuck output
  ltg_sync #(.WIDTH(1)) u_sync_rxfb (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .async_i(rxd_fb_i),
    .sync_o(rxfb_sync)
  );

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + 1'b1;
  endfunction

  localparam logic [CNT_W-1:0] WAKE_LIM = WAKE_CYCLES[CNT_W-1:0];
  localparam logic [CNT_W-1:0] STUCK_LIM = RX_STUCK_CYCLES[CNT_W-1:0];
  localparam logic [CNT_W-1:0] SHORT_LIM = SHORT_CYCLES[CNT_W-1:0];

  // -----------------------------------------------------------------
  // fault detectors
  // -----------------------------------------------------------------
  logic [CNT_W-1:0] short_cnt, next_short_cnt;
  logic [CNT_W-1:0] stuck_cnt, next_stuck_cnt;
  logic [CNT_W-1:0] wake_cnt, next_wake_cnt;
  logic wake_armed, next_wake_armed;
  logic txd_prev, next_txd_prev;
  logic short_hit, stuck_hit, stuck_now, wake_hit;

  // short: host drives dominant but rxd pin stays recessive with the
  // bus itself dominant, so the two pins are tied together externally
  always_comb begin
    next_short_cnt = '0;
    if (!pins.txd && !pins.bus && rxfb_sync[0]) begin
      next_short_cnt = sat_inc(short_cnt, SHORT_LIM);
    end
    next_stuck_cnt = '0;
    if (!pins.bus && rxfb_sync[0] && pins.txd) begin
      next_stuck_cnt = sat_inc(stuck_cnt, STUCK_LIM);
    end
    // count consecutive dominant cycles, any recessive sample restarts
    next_wake_cnt = '0;
    if (wake_capable_i && !pins.bus) begin
      next_wake_cnt = sat_inc(wake_cnt, WAKE_LIM);
    end
    // one wake per dominant stretch; rearm on recessive
    next_wake_armed = wake_armed;
    if (pins.bus || !wake_capable_i) begin
      next_wake_armed = 1'b1;
    end else if (next_wake_cnt == WAKE_LIM) begin
      next_wake_armed = 1'b0;
    end
    next_txd_prev = pins.txd;
  end

  assign short_hit = (next_short_cnt == SHORT_LIM) && (short_cnt != SHORT_LIM);
  assign stuck_now = (stuck_cnt == STUCK_LIM);
  assign stuck_hit = (next_stuck_cnt == STUCK_LIM) && !stuck_now;
  assign wake_hit = wake_armed && (next_wake_cnt == WAKE_LIM);

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      short_cnt <= '0;
      stuck_cnt <= '0;
      wake_cnt <= '0;
      wake_armed <= 1'b1;
      txd_prev <= 1'b1;
    end else begin
      short_cnt <= next_short_cnt;
      stuck_cnt <= next_stuck_cnt;
      wake_cnt <= next_wake_cnt;
      wake_armed <= next_wake_armed;
      txd_prev <= next_txd_prev;
    end
  end

  // -----------------------------------------------------------------
  // transmitter state machine
  // -----------------------------------------------------------------
  ltg_tx_state_e state, next_state;
  logic latch_short, next_latch_short;
  logic latch_stuck, next_latch_stuck;
  logic txd_rise;

  assign txd_rise = !txd_prev && pins.txd;

  // latched faults: a new hit wins over a host command in the same cycle
  always_comb begin
    next_latch_short = latch_short;
    next_latch_stuck = latch_stuck;
    if (normal_cmd_i) begin
      next_latch_short = 1'b0;
      next_latch_stuck = 1'b0;
    end
    if (short_hit) begin
      next_latch_short = 1'b1;
    end
    if (stuck_hit || stuck_now) begin
      next_latch_stuck = 1'b1;
    end
  end

  // overtemperature outranks the latched faults; it releases itself
  always_comb begin
    next_state = state;
    case (state)
      LTG_NORMAL: begin
        if (overtemp_i) begin
          next_state = LTG_OVERTEMP;
        end else if (next_latch_short || next_latch_stuck) begin
          next_state = LTG_RX_ONLY;
        end
      end
      LTG_RX_ONLY: begin
        if (overtemp_i) begin
          next_state = LTG_OVERTEMP;
        end else if (!next_latch_short && !next_latch_stuck) begin
          next_state = LTG_NORMAL;
        end
      end
      LTG_OVERTEMP: begin
        if (!overtemp_i) begin
          next_state = LTG_OT_WAIT;
        end
      end
      LTG_OT_WAIT: begin
        if (overtemp_i) begin
          next_state = LTG_OVERTEMP;
        end else if (txd_rise) begin
          // a latched fault still keeps the driver off
          next_state = (next_latch_short || next_latch_stuck) ? LTG_RX_ONLY
                                                              : LTG_NORMAL;
        end
      end
      default: next_state = LTG_RX_ONLY;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state <= LTG_NORMAL;
      latch_short <= 1'b0;
      latch_stuck <= 1'b0;
    end else begin
      state <= next_state;
      latch_short <= next_latch_short;
      latch_stuck <= next_latch_stuck;
    end
  end

  // -----------------------------------------------------------------
  // pin outputs
  // -----------------------------------------------------------------
  logic next_drv_en, next_drv_dom, next_rxd, next_wake;

  // reception runs in every state; only the driver is gated
  always_comb begin
    next_drv_en = (state == LTG_NORMAL);
    next_drv_dom = (state == LTG_NORMAL) && !pins.txd;
    next_rxd = pins.bus;
    next_wake = wake_hit;
  end

  assign rx_only_o = !drv_en_o;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      drv_en_o <= 1'b0;
      drv_dominant_o <= 1'b0;
      rxd_o <= 1'b1;
      wake_o <= 1'b0;
    end else begin
      drv_en_o <= next_drv_en;
      drv_dominant_o <= next_drv_dom;
      rxd_o <= next_rxd;
      wake_o <= next_wake;
    end
  end

  // -----------------------------------------------------------------
  // diagnostic event queue toward the spi encoder
  // -----------------------------------------------------------------
  // overtemperature is deliberately absent from the event word
  ltg_evt_s evt_in;
  logic evt_valid, evt_ready, next_drop;

  assign evt_in = '{tx_rx_short: short_hit, rx_stuck: stuck_hit, wake: wake_hit};
  assign evt_valid = short_hit || stuck_hit || wake_hit;

  ltg_fifo #(.WIDTH(EVT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(evt_valid),
    .in_ready_o(evt_ready),
    .in_data_i(evt_in),
    .out_valid_o(diag_valid_o),
    .out_ready_i(diag_ready_i),
    .out_data_o(diag_evt_o)
  );

  // events cannot be stalled at their source, so overflow is flagged
  always_comb begin
    next_drop = evt_valid && !evt_ready;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      evt_drop_o <= 1'b0;
    end else begin
      evt_drop_o <= next_drop;
    end
  end

endmodule
`default_nettype wire

// File: verif/ltg_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module ltg_far_model (
  input wire logic drv_dominant_i,
  input wire logic other_dom_i,
  input wire logic rxd_i,
  input wire logic rxd_fault_i,
  output logic bus_o,
  output logic rxd_fb_o
);
  // wired-and bus with pull-up: recessive unless a node pulls low
  assign bus_o = !(drv_dominant_i || other_dom_i);
  // a clamped or shorted rxd line reads recessive whatever we send
  assign rxd_fb_o = rxd_fault_i ? 1'b1 : rxd_i;
endmodule
`default_nettype wire

// File: verif/ltg_guard_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ltg_guard_chk
  import ltg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic txd_pin_i,
  input wire logic bus_pin_i,
  input wire logic rxd_fb_i,
  input wire logic overtemp_i,
  input wire logic wake_capable_i,
  input wire logic normal_cmd_i,
  input wire logic rxd_o,
  input wire logic drv_en_o,
  input wire logic drv_dominant_o,
  input wire logic rx_only_o,
  input wire logic wake_o,
  input wire logic diag_valid_o,
  input wire logic diag_ready_i,
  input wire ltg_evt_s diag_evt_o,
  input wire logic evt_drop_o
);
  // ----
  // helpers
  // ----
  logic [3:0] up;
  logic [3:0] cause;
  logic txd_q;
  logic [3:0] next_up;
  logic [3:0] next_cause;
  // cause restarts on a host command or a txd rising edge, so a late
  // re-enable with no trigger shows as a large count
  always_comb begin
    next_up = (up == 4'hF) ? up : up + 4'h1;
    next_cause = (cause == 4'hF) ? cause : cause + 4'h1;
    if (normal_cmd_i || (txd_pin_i && !txd_q) || !rstn_i)
      next_cause = 4'h0;
    if (!rstn_i)
      next_up = 4'h0;
  end
  always_ff @(posedge core_clk_i) begin
    txd_q <= txd_pin_i;
    up <= next_up;
    cause <= next_cause;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence en_rise_s;
    !drv_en_o ##1 drv_en_o;
  endsequence

  rx_only_a: assert property (rx_only_o == !drv_en_o)
    else $error("rx only not inverse of driver enable");
  drv_gate_a: assert property (!drv_en_o |-> !drv_dominant_o)
    else $error("driver dominant while disabled");
  ot_off_a: assert property (overtemp_i |-> ##3 !drv_en_o)
    else $error("driver on during overtemperature");
  no_ot_evt_a: assert property (diag_valid_o |-> diag_evt_o != 3'h0)
    else $error("empty diagnostic word");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  wake_bus_a: assert property (wake_o |-> !rxd_o && $past(!rxd_o, 8))
    else $error("wake without dominant bus");
  rise_cause_a: assert property (en_rise_s |-> cause < 4'h8)
    else $error("driver re-enabled without cause");
  drv_follow_a: assert property (drv_en_o && up > 4'h4 |->
    drv_dominant_o == !$past(txd_pin_i, 3))
    else $error("driver does not follow txd");
  rxd_follow_a: assert property (up > 4'h4 |-> rxd_o == $past(bus_pin_i, 3))
    else $error("rxd does not follow bus");
endmodule
`default_nettype wire

// File: verif/lin_transmitter_fault_guard_test.sv
`timescale 1ns/10ps
`default_nettype none
module lin_transmitter_fault_guard_test;
  import ltg_pkg::*;
  logic core_clk_i, rstn_i, txd_pin_i, overtemp_i, wake_capable_i;
  logic normal_cmd_i, diag_ready_i, other_dom, rxd_fault;
  wire logic bus_pin_i, rxd_fb_i;
  logic rxd_o, drv_en_o, drv_dominant_o, rx_only_o, wake_o, diag_valid_o, evt_drop_o;
  ltg_evt_s diag_evt_o;
  int fails, samples_checked, drops, pops;

  ltg_guard dut (.core_clk_i, .rstn_i, .txd_pin_i, .bus_pin_i, .rxd_fb_i, .overtemp_i,
    .wake_capable_i, .normal_cmd_i, .rxd_o, .drv_en_o, .drv_dominant_o, .rx_only_o,
    .wake_o, .diag_valid_o, .diag_ready_i, .diag_evt_o, .evt_drop_o);
  ltg_far_model far (.drv_dominant_i(drv_dominant_o), .other_dom_i(other_dom),
    .rxd_i(rxd_o), .rxd_fault_i(rxd_fault), .bus_o(bus_pin_i), .rxd_fb_o(rxd_fb_i));

  // ----
  // helpers
  // ----
  always @(posedge core_clk_i) begin
    if (evt_drop_o === 1'b1)
      drops++;
    if (diag_valid_o === 1'b1 && diag_ready_i === 1'b1)
      pops++;
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  function automatic logic pick(input int sel);
    return (sel == 1) ? wake_o : drv_en_o;
  endfunction
  // bounded wait, sel 0 = driver enable, 1 = wake; n returns edges used
  task automatic wait_for(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while (pick(sel) !== lvl && n < lim) begin
      cyc(1);
      #1;
      n++;
    end
    if (pick(sel) !== lvl) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pick(sel), lvl);
      give_verdict();
    end
  endtask
  task automatic pop(input logic [2:0] exp);
    chk(diag_valid_o, 1'b1);
    chk(diag_evt_o, exp);
    cyc(1);
    diag_ready_i <= 1'b1;
    cyc(1);
    diag_ready_i <= 1'b0;
    #1;
  endtask
  // host command pulse; the stuck and fifo tests also send it while the fault cause is still present
  task automatic send_cmd();
    cyc(1);
    normal_cmd_i <= 1'b1;
    cyc(1);
    normal_cmd_i <= 1'b0;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_short();
    int n;
    cyc(1);
    txd_pin_i <= 1'b0;
    rxd_fault <= 1'b1;
    cyc(8);
    #1;
    chk(drv_dominant_o, 1'b1);
    wait_for(0, 1'b0, SHORT_CYCLES + 16, n);
    chk(n >= SHORT_CYCLES - 12, 1'b1);
    chk(rx_only_o, 1'b1);
    pop(3'h4);
    cyc(1);
    txd_pin_i <= 1'b1;
    rxd_fault <= 1'b0;
    cyc(20);
    #1;
    chk(drv_en_o, 1'b0);
    send_cmd();
    wait_for(0, 1'b1, 8, n);
    $display("short test done");
  endtask
  task automatic t_ot();
    int n;
    cyc(1);
    overtemp_i <= 1'b1;
    other_dom <= 1'b1;
    cyc(8);
    #1;
    chk(drv_en_o, 1'b0);
    chk(rxd_o, 1'b0);
    cyc(1);
    overtemp_i <= 1'b0;
    other_dom <= 1'b0;
    txd_pin_i <= 1'b0;
    cyc(20);
    #1;
    chk(drv_en_o, 1'b0);
    chk(diag_valid_o, 1'b0);
    cyc(1);
    txd_pin_i <= 1'b1;
    wait_for(0, 1'b1, 10, n);
    $display("overtemp test done");
  endtask
  task automatic t_stuck();
    int n;
    cyc(1);
    other_dom <= 1'b1;
    rxd_fault <= 1'b1;
    wait_for(0, 1'b0, RX_STUCK_CYCLES + 16, n);
    chk(n >= RX_STUCK_CYCLES - 12, 1'b1);
    pop(3'h2);
    send_cmd();
    cyc(20);
    #1;
    chk(drv_en_o, 1'b0);
    other_dom <= 1'b0;
    rxd_fault <= 1'b0;
    // let the synchronised bus go recessive first, else stuck relatches
    cyc(8);
    send_cmd();
    wait_for(0, 1'b1, 8, n);
    $display("stuck test done");
  endtask
  task automatic t_wake();
    int n;
    cyc(1);
    diag_ready_i <= 1'b1;
    wake_capable_i <= 1'b1;
    other_dom <= 1'b1;
    cyc(WAKE_CYCLES - 100);
    other_dom <= 1'b0;
    diag_ready_i <= 1'b0;
    cyc(4);
    other_dom <= 1'b1;
    wait_for(1, 1'b1, WAKE_CYCLES + 16, n);
    chk(n >= WAKE_CYCLES - 2, 1'b1);
    cyc(1);
    #1;
    chk(wake_o, 1'b0);
    pop(3'h1);
    other_dom <= 1'b0;
    wake_capable_i <= 1'b0;
    $display("wake test done");
  endtask
  // fill the event buffer until it drops, then drain it with ready held
  task automatic t_fifo();
    int n;
    cyc(1);
    drops = 0;
    txd_pin_i <= 1'b0;
    rxd_fault <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wait_for(0, 1'b0, SHORT_CYCLES + 16, n);
      send_cmd();
      wait_for(0, 1'b1, 8, n);
    end
    txd_pin_i <= 1'b1;
    rxd_fault <= 1'b0;
    cyc(4);
    #1;
    chk(drops, 8'h01);
    pops = 0;
    diag_ready_i <= 1'b1;
    cyc(20);
    #1;
    chk(pops, 8'h08);
    chk(diag_valid_o, 1'b0);
    $display("fifo test done");
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  initial begin
    rstn_i = 1'b0;
    txd_pin_i = 1'b1;
    overtemp_i = 1'b0;
    wake_capable_i = 1'b0;
    normal_cmd_i = 1'b0;
    diag_ready_i = 1'b0;
    other_dom = 1'b0;
    rxd_fault = 1'b0;
    fails = 0;
    samples_checked = 0;
    cyc(2);
    rstn_i <= 1'b1;
    cyc(3);
    t_short();
    t_ot();
    t_stuck();
    t_wake();
    t_fifo();
    give_verdict();
  end
endmodule

bind ltg_guard ltg_guard_chk u_chk (.core_clk_i, .rstn_i, .txd_pin_i, .bus_pin_i,
  .rxd_fb_i, .overtemp_i, .wake_capable_i, .normal_cmd_i, .rxd_o, .drv_en_o,
  .drv_dominant_o, .rx_only_o, .wake_o, .diag_valid_o, .diag_ready_i, .diag_evt_o,
  .evt_drop_o);
`default_nettype wire
